// ===== logic/cft_pkg.sv
package cft_pkg;

   // Register offsets (word addresses on the plain port)
   localparam logic [3:0] ADDR_MASK = 4'h0;
   localparam logic [3:0] ADDR_COMP = 4'h1;
   localparam logic [3:0] ADDR_CTRL = 4'h2;
   localparam logic [3:0] ADDR_TRIG = 4'h3;
   localparam logic [3:0] ADDR_CMD = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_WARN = 4'h6;
   localparam logic [3:0] ADDR_TXDATA = 4'h7;

   // Reset values
   localparam logic [31:0] MASK_RESET = 32'h0FFFFFFF;
   localparam logic [31:0] COMP_RESET = 32'h00000000;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;
   localparam logic [31:0] TRIG_RESET = 32'h00000000;

   // Control field positions
   localparam int CTRL_AUTO_START = 0;
   localparam int CTRL_NO_RETRY = 1;
   localparam int CTRL_WARN_LOG = 2;
   localparam int CTRL_LAYOUT_LSB = 4;

   // Trigger field positions
   localparam int TRIG_MODE_LSB = 0;
   localparam int TRIG_TOGGLE = 4;
   localparam int TRIG_LINE_LSB = 8;
   localparam int TRIG_SKIP_LSB = 16;

   // Command bits
   localparam int CMD_START = 0;
   localparam int CMD_TRIG_OUT = 1;

   // Queue entry constants
   localparam logic [31:0] TRIG_STAMP_ID = 32'h40000001;
   localparam logic [1:0] WARN_FRAME_TYPE = 2'h2;
   localparam logic [1:0] TRIG_STAMP_FRAME_TYPE = 2'h3;
   localparam logic [3:0] WARN_FRAME_LEN = 4'h0;
   localparam logic [2:0] TRIG_LINE_MAX = 3'h6;

   // Pulse timing
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int PULSE_MIN_NS = 100;
   localparam int PULSE_CYCLES = (PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   localparam int TX_QUEUE_DEPTH = 10;

   typedef enum logic [2:0] {
      CFT_TRIGGER_OFF = 3'h0,
      CFT_TRIGGER_OUT_ON_COMMAND = 3'h1,
      CFT_TRIGGER_OUT_ON_RECEIVE = 3'h2,
      CFT_TRIGGER_OUT_ON_TRANSMIT = 3'h3,
      CFT_TIMESTAMP_ON_TRIGGER_IN = 3'h4,
      CFT_TRANSMIT_ON_TRIGGER_IN = 3'h5
   } cft_trigger_mode_t;

   typedef enum logic [1:0] {
      CFT_TX_IDLE = 2'b00,
      CFT_TX_BUSY = 2'b01,
      CFT_TX_DONE = 2'b11
   } cft_tx_state_t;

endpackage

// ===== logic/cft_can_filter_retry_trigger.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module cft_can_filter_retry_trigger
#(
   parameter int QUEUE_DEPTH = cft_pkg::TX_QUEUE_DEPTH,
   parameter int FRAME_WIDTH = 32
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Received frame from the CAN core
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic rx_rtr,
   input wire logic [7:0] rx_data0,
   input wire logic [7:0] rx_data1,
   input wire logic [31:0] rx_full_id,
   // Receive queue write side
   output logic rxq_push,
   output logic [31:0] rxq_id,
   output logic [31:0] rxq_stamp,
   output logic [1:0] rxq_frame_type,
   output logic [3:0] rxq_len,
   // Warnings from the CAN core
   input wire logic warn_valid,
   input wire logic [31:0] warn_id,
   // Free-running timestamp
   input wire logic [31:0] timestamp,
   // Transmit engine
   output logic tx_start,
   output logic [FRAME_WIDTH-1:0] tx_frame,
   input wire logic tx_done_ok,
   input wire logic tx_done_fail,
   output logic bus_on,
   // Board trigger bus, seven lines
   input wire logic [6:0] trig_in,
   output logic [6:0] trig_out,
   output logic [6:0] trig_oe
);

   localparam int PTR_W = $clog2(QUEUE_DEPTH + 1);
   localparam logic [2:0] PULSE_LEN = 3'(cft_pkg::PULSE_CYCLES);

   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] comp;
      logic [31:0] ctrl;
      logic [31:0] trig;
      logic started;
      logic warn_flag;
      logic [31:0] warn_last;
      logic [31:0] rdata;
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] sync_prev;
      logic [15:0] skip_cnt;
      logic trig_level;
      logic [2:0] pulse_cnt;
      logic [QUEUE_DEPTH-1:0][FRAME_WIDTH-1:0] queue;
      logic [PTR_W-1:0] count;
      logic [FRAME_WIDTH-1:0] last_frame;
      logic have_last;
      logic from_queue;
      cft_pkg::cft_tx_state_t tx_state;
      logic rxq_push;
      logic [31:0] rxq_id;
      logic [31:0] rxq_stamp;
      logic [1:0] rxq_frame_type;
      logic [3:0] rxq_len;
      logic tx_start;
      logic [FRAME_WIDTH-1:0] tx_frame;
   } cft_state_t;

   cft_state_t r;
   cft_state_t next_r;

   logic accept;
   logic [27:0] frame_bits;
   logic [2:0] line;
   cft_pkg::cft_trigger_mode_t mode;
   logic input_mode;
   logic edge_seen;
   logic act_edge;
   logic out_event;
   logic tx_event;
   logic cmd_trig;
   logic q_write;

   always_comb
   begin
      next_r = r;
      next_r.rxq_push = 1'b0;
      next_r.tx_start = 1'b0;
      mode = cft_pkg::cft_trigger_mode_t'(r.trig[cft_pkg::TRIG_MODE_LSB +: 3]);
      line = (r.trig[cft_pkg::TRIG_LINE_LSB +: 3] > cft_pkg::TRIG_LINE_MAX)
         ? cft_pkg::TRIG_LINE_MAX : r.trig[cft_pkg::TRIG_LINE_LSB +: 3];
      input_mode = (mode == cft_pkg::CFT_TIMESTAMP_ON_TRIGGER_IN)
         || (mode == cft_pkg::CFT_TRANSMIT_ON_TRIGGER_IN);
      cmd_trig = 1'b0;
      q_write = 1'b0;
      tx_event = 1'b0;

      // Register access; read data stands one cycle later
      next_r.rdata = 32'h00000000;
      if (reg_read)
      begin
         unique case (reg_addr)
            cft_pkg::ADDR_MASK: next_r.rdata = r.mask;
            cft_pkg::ADDR_COMP: next_r.rdata = r.comp;
            cft_pkg::ADDR_CTRL: next_r.rdata = r.ctrl;
            cft_pkg::ADDR_TRIG: next_r.rdata = r.trig;
            cft_pkg::ADDR_STATUS: next_r.rdata = {24'h000000, r.have_last, 4'(r.count),
               r.trig_level, r.warn_flag, r.started};
            cft_pkg::ADDR_WARN: next_r.rdata = r.warn_last;
            default: next_r.rdata = 32'h00000000;
         endcase
         // Reading status consumes the warning flag
         if (reg_addr == cft_pkg::ADDR_STATUS)
            next_r.warn_flag = 1'b0;
      end
      if (reg_write)
      begin
         unique case (reg_addr)
            cft_pkg::ADDR_MASK: next_r.mask = {4'h0, reg_wdata[27:0]};
            cft_pkg::ADDR_COMP: next_r.comp = {4'h0, reg_wdata[27:0]};
            cft_pkg::ADDR_CTRL: next_r.ctrl = reg_wdata;
            cft_pkg::ADDR_TRIG: next_r.trig = reg_wdata;
            cft_pkg::ADDR_CMD:
            begin
               if (reg_wdata[cft_pkg::CMD_START])
                  next_r.started = 1'b1;
               cmd_trig = reg_wdata[cft_pkg::CMD_TRIG_OUT];
            end
            cft_pkg::ADDR_TXDATA: q_write = 1'b1;
            default: ;
         endcase
      end

      // Auto-start: communication runs from release of reset
      if (r.ctrl[cft_pkg::CTRL_AUTO_START])
         next_r.started = 1'b1;

      // Acceptance filter, single standard layout
      // Identifier on top so no identifier bit falls outside the 28 compared bits
      frame_bits = {rx_id, rx_rtr, rx_data0, rx_data1};
      accept = &(r.mask[27:0] | ~(frame_bits ^ r.comp[27:0]));

      // Trigger input sync and edge detect
      next_r.sync1 = trig_in;
      next_r.sync2 = r.sync1;
      next_r.sync_prev = r.sync2;
      edge_seen = input_mode && r.sync2[line] && !r.sync_prev[line];
      act_edge = 1'b0;
      if (edge_seen)
      begin
         if (r.skip_cnt >= r.trig[cft_pkg::TRIG_SKIP_LSB +: 16])
         begin
            act_edge = 1'b1;
            next_r.skip_cnt = 16'h0000;
         end
         else
            next_r.skip_cnt = r.skip_cnt + 16'h0001;
      end
      if (!input_mode)
         next_r.skip_cnt = 16'h0000;

      // Receive queue entries; one per cycle, timestamp entry first
      if (act_edge && mode == cft_pkg::CFT_TIMESTAMP_ON_TRIGGER_IN)
      begin
         next_r.rxq_push = 1'b1;
         next_r.rxq_id = cft_pkg::TRIG_STAMP_ID;
         next_r.rxq_stamp = timestamp;
         next_r.rxq_frame_type = cft_pkg::TRIG_STAMP_FRAME_TYPE;
         next_r.rxq_len = {1'b0, line};
      end
      else if (rx_valid && accept && r.started)
      begin
         next_r.rxq_push = 1'b1;
         next_r.rxq_id = rx_full_id;
         next_r.rxq_stamp = timestamp;
         next_r.rxq_frame_type = {1'b0, rx_rtr};
         next_r.rxq_len = 4'h8;
      end
      else if (warn_valid && r.ctrl[cft_pkg::CTRL_WARN_LOG])
      begin
         next_r.rxq_push = 1'b1;
         next_r.rxq_id = warn_id;
         next_r.rxq_stamp = timestamp;
         next_r.rxq_frame_type = cft_pkg::WARN_FRAME_TYPE;
         next_r.rxq_len = cft_pkg::WARN_FRAME_LEN;
      end
      // Warning with logging off, or crowded out of the queue this cycle
      if (warn_valid && !(r.ctrl[cft_pkg::CTRL_WARN_LOG] && next_r.rxq_push
         && next_r.rxq_frame_type == cft_pkg::WARN_FRAME_TYPE))
      begin
         next_r.warn_flag = 1'b1;
         next_r.warn_last = warn_id;
      end

      // Transmit engine handshake
      unique case (r.tx_state)
         cft_pkg::CFT_TX_IDLE:
         begin
            if (r.started && r.count != '0 && mode != cft_pkg::CFT_TRANSMIT_ON_TRIGGER_IN)
            begin
               next_r.tx_start = 1'b1;
               next_r.tx_frame = r.queue[0];
               next_r.from_queue = 1'b1;
               next_r.tx_state = cft_pkg::CFT_TX_BUSY;
            end
            else if (r.started && act_edge && mode == cft_pkg::CFT_TRANSMIT_ON_TRIGGER_IN)
            begin
               if (r.count != '0)
               begin
                  next_r.tx_start = 1'b1;
                  next_r.tx_frame = r.queue[0];
                  next_r.from_queue = 1'b1;
                  next_r.tx_state = cft_pkg::CFT_TX_BUSY;
               end
               else if (r.have_last)
               begin
                  next_r.tx_start = 1'b1;
                  next_r.tx_frame = r.last_frame;
                  next_r.from_queue = 1'b0;
                  next_r.tx_state = cft_pkg::CFT_TX_BUSY;
               end
            end
         end
         cft_pkg::CFT_TX_BUSY:
         begin
            if (tx_done_ok)
            begin
               tx_event = r.from_queue;
               next_r.tx_state = cft_pkg::CFT_TX_DONE;
            end
            else if (tx_done_fail)
            begin
               if (r.ctrl[cft_pkg::CTRL_NO_RETRY])
                  next_r.tx_state = cft_pkg::CFT_TX_DONE;
               else
                  next_r.tx_start = 1'b1;
            end
         end
         cft_pkg::CFT_TX_DONE:
            next_r.tx_state = cft_pkg::CFT_TX_IDLE;
         default:
            next_r.tx_state = cft_pkg::CFT_TX_IDLE;
      endcase

      // Queue pop on completion, push on write; full queue drops writes
      if (r.tx_state == cft_pkg::CFT_TX_DONE && r.from_queue)
      begin
         for (int i = 0; i < QUEUE_DEPTH - 1; i++)
            next_r.queue[i] = r.queue[i + 1];
         next_r.count = r.count - PTR_W'(1);
      end
      if (q_write && next_r.count < PTR_W'(QUEUE_DEPTH))
      begin
         next_r.queue[next_r.count] = reg_wdata[FRAME_WIDTH-1:0];
         next_r.count = next_r.count + PTR_W'(1);
         next_r.last_frame = reg_wdata[FRAME_WIDTH-1:0];
         next_r.have_last = 1'b1;
      end

      // Trigger output events
      unique case (mode)
         cft_pkg::CFT_TRIGGER_OUT_ON_COMMAND: out_event = cmd_trig;
         cft_pkg::CFT_TRIGGER_OUT_ON_RECEIVE:
            out_event = next_r.rxq_push && next_r.rxq_frame_type[1] == 1'b0;
         cft_pkg::CFT_TRIGGER_OUT_ON_TRANSMIT: out_event = tx_event;
         default: out_event = 1'b0;
      endcase
      if (r.pulse_cnt != 3'h0)
         next_r.pulse_cnt = r.pulse_cnt - 3'h1;
      if (out_event)
      begin
         if (r.trig[cft_pkg::TRIG_TOGGLE])
            next_r.trig_level = ~r.trig_level;
         else
            next_r.pulse_cnt = PULSE_LEN;
      end
      if (!r.trig[cft_pkg::TRIG_TOGGLE])
         next_r.trig_level = 1'b0;
      if (input_mode || mode == cft_pkg::CFT_TRIGGER_OFF)
      begin
         next_r.trig_level = 1'b0;
         next_r.pulse_cnt = 3'h0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r <= '0;
         r.mask <= cft_pkg::MASK_RESET;
         r.comp <= cft_pkg::COMP_RESET;
         r.ctrl <= cft_pkg::CTRL_RESET;
         r.trig <= cft_pkg::TRIG_RESET;
         r.tx_state <= cft_pkg::CFT_TX_IDLE;
      end
      else
         r <= next_r;
   end

   logic drive;
   logic out_mode;

   always_comb
   begin
      out_mode = (mode == cft_pkg::CFT_TRIGGER_OUT_ON_COMMAND)
         || (mode == cft_pkg::CFT_TRIGGER_OUT_ON_RECEIVE)
         || (mode == cft_pkg::CFT_TRIGGER_OUT_ON_TRANSMIT);
      drive = r.trig_level | (r.pulse_cnt != 3'h0);
      trig_out = 7'h00;
      trig_oe = 7'h00;
      if (out_mode)
      begin
         trig_out[line] = drive;
         trig_oe[line] = 1'b1;
      end
   end

   assign reg_rdata = r.rdata;
   assign rxq_push = r.rxq_push;
   assign rxq_id = r.rxq_id;
   assign rxq_stamp = r.rxq_stamp;
   assign rxq_frame_type = r.rxq_frame_type;
   assign rxq_len = r.rxq_len;
   assign tx_start = r.tx_start;
   assign tx_frame = r.tx_frame;
   assign bus_on = r.started;

endmodule

`default_nettype wire

// ===== verification/cft_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cft_checker
#(
   parameter int FRAME_WIDTH = 32
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Receive side
   input wire logic rx_valid,
   input wire logic rx_rtr,
   input wire logic [31:0] rx_full_id,
   input wire logic rxq_push,
   input wire logic [31:0] rxq_id,
   input wire logic [31:0] rxq_stamp,
   input wire logic [1:0] rxq_frame_type,
   input wire logic [3:0] rxq_len,
   input wire logic warn_valid,
   input wire logic [31:0] warn_id,
   input wire logic [31:0] timestamp,
   // Transmit and trigger side
   input wire logic tx_start,
   input wire logic [FRAME_WIDTH-1:0] tx_frame,
   input wire logic tx_done_fail,
   input wire logic bus_on,
   input wire logic [6:0] trig_out,
   input wire logic [6:0] trig_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence fail_then_start;
      tx_done_fail ##1 tx_start;
   endsequence
   sequence frame_push;
      rxq_push && !rxq_frame_type[1];
   endsequence
   line_onehot_a: assert property ($onehot0(trig_oe))
      else $error("more than one trigger line driven");
   out_in_oe_a: assert property ((trig_out & ~trig_oe) == 7'h00)
      else $error("trigger level on an undriven line");
   frame_entry_a: assert property (frame_push |-> $past(rx_valid) && rxq_len == 4'h8
      && rxq_id == $past(rx_full_id) && rxq_frame_type[0] == $past(rx_rtr))
      else $error("frame entry does not match the received frame");
   warn_entry_a: assert property (rxq_push && rxq_frame_type == 2'h2 |->
      $past(warn_valid) && rxq_id == $past(warn_id) && rxq_len == 4'h0
      && rxq_stamp == $past(timestamp)) else $error("bad warning entry");
   stamp_entry_a: assert property (rxq_push && rxq_frame_type == 2'h3 |->
      rxq_id == cft_pkg::TRIG_STAMP_ID && rxq_len <= 4'h6 && rxq_stamp == $past(timestamp))
      else $error("bad stamp entry");
   retry_same_a: assert property (fail_then_start |-> tx_frame == $past(tx_frame))
      else $error("retry sent another frame");
   start_bus_a: assert property (tx_start |-> bus_on)
      else $error("transmission before start");
   auto_start_a: assert property ($past(sys_rst) |=> bus_on)
      else $error("auto start missing");
   bus_kept_a: assert property (!$fell(bus_on))
      else $error("communication stopped");
endmodule
bind cft_can_filter_retry_trigger cft_checker #(.FRAME_WIDTH(FRAME_WIDTH)) chk (.clock, .sys_rst,
   .rx_valid, .rx_rtr, .rx_full_id, .rxq_push, .rxq_id, .rxq_stamp, .rxq_frame_type, .rxq_len,
   .warn_valid, .warn_id, .timestamp, .tx_start, .tx_frame, .tx_done_fail, .bus_on, .trig_out,
   .trig_oe);
`default_nettype wire

// ===== verification/cft_tx_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cft_tx_partner
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Transmit engine side
   input wire logic tx_start,
   input wire logic [31:0] tx_frame,
   output logic tx_done_ok,
   output logic tx_done_fail,
   // Bench control and view
   input wire logic fail_all,
   input wire logic [3:0] delay,
   output int starts,
   output logic [31:0] last_frame
);
   initial
   begin
      tx_done_ok = 1'b0;
      tx_done_fail = 1'b0;
      starts = 0;
   end
   // Answers only while busy, one result per attempt
   always @(posedge clock)
   begin
      if (tx_start && !sys_rst)
      begin
         starts <= starts + 1;
         last_frame <= tx_frame;
         repeat (delay) @(posedge clock);
         // Lost arbitration and missing ack look alike to the design
         tx_done_ok <= !fail_all;
         tx_done_fail <= fail_all;
         @(posedge clock);
         tx_done_ok <= 1'b0;
         tx_done_fail <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== verification/test_can_filter_retry_trigger.sv
`timescale 1ns/100ps
`default_nettype none
module test_can_filter_retry_trigger;
   typedef struct {logic [27:0] m; logic [27:0] c; logic [10:0] id; logic r;
      logic [15:0] d; logic ok;} cft_row_t;
   logic clock = 0, sys_rst = 1, reg_write = 0, reg_read = 0, rx_valid = 0, rx_rtr = 0;
   logic [3:0] reg_addr = 0, delay = 0;
   logic [31:0] reg_wdata = 0, rx_full_id = 0, warn_id = 0, timestamp = 0, reg_rdata, rxq_id;
   logic [31:0] rxq_stamp, tx_frame, last_frame;
   logic [10:0] rx_id = 0;
   logic [7:0] rx_data0 = 0, rx_data1 = 0;
   logic [6:0] trig_in = 0, trig_out, trig_oe;
   logic [3:0] rxq_len;
   logic [3:0] stamp_len = 0;
   logic [1:0] rxq_frame_type;
   logic warn_valid = 0, fail_all = 0, rxq_push, tx_start, tx_done_ok, tx_done_fail, bus_on;
   int checks = 0, error_cnt = 0, cyc = 0, outs = 0, stamps = 0, hi = 0, minhi = 99, s;
   int s_now;
   cft_row_t rows [9] = '{'{28'hFFFFFFF, 0, 11'h5A5, 1, 16'h1234, 1},
      '{0, 0, 0, 0, 0, 1}, '{0, 0, 11'h001, 0, 0, 0}, '{0, 0, 0, 1, 0, 0},
      '{0, 0, 0, 0, 16'h0001, 0}, '{0, 28'h00000AB, 0, 0, 16'h00AB, 1},
      '{0, 0, 0, 0, 16'h8000, 0}, '{28'hFFFFF00, 28'h5, 11'h7FF, 1, 16'h0005, 1},
      '{28'hFFFFF00, 28'h5, 0, 0, 16'h0006, 0}};
   cft_can_filter_retry_trigger dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .rx_valid, .rx_id, .rx_rtr, .rx_data0, .rx_data1, .rx_full_id,
      .rxq_push, .rxq_id, .rxq_stamp, .rxq_frame_type, .rxq_len, .warn_valid, .warn_id,
      .timestamp, .tx_start, .tx_frame, .tx_done_ok, .tx_done_fail, .bus_on, .trig_in,
      .trig_out, .trig_oe);
   cft_tx_partner far (.clock, .sys_rst, .tx_start, .tx_frame, .tx_done_ok, .tx_done_fail,
      .fail_all, .delay, .starts(s_now), .last_frame);
   always #25 clock = ~clock;
   always @(posedge clock)
   begin
      timestamp <= timestamp + 1;
      cyc++;
      if (rxq_push && rxq_frame_type === 2'h3)
      begin
         stamps++;
         stamp_len = rxq_len;
      end
      // High times measured in every mode, toggle mode included; toggle levels are also checked directly
      if (|trig_out)
         hi++;
      else if (hi > 0)
      begin
         outs++;
         minhi = (hi < minhi) ? hi : minhi;
         hi = 0;
      end
      if (cyc == 4000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 check(n, reg_rdata, e);
   endtask
   // One-cycle frame or warning; push sampled once the taking edge has landed
   task automatic ev(input logic w, input logic [10:0] id, input logic r, input logic [15:0] d);
      @(posedge clock);
      {rx_valid, warn_valid, rx_id, rx_rtr, rx_data0, rx_data1} <= {!w, w, id, r, d};
      rx_full_id <= {21'h0, id};
      warn_id <= {21'h0, id};
      @(posedge clock);
      {rx_valid, warn_valid} <= 2'b00;
      #1;
   endtask
   task automatic edge_in(input int l, input int n);
      repeat (n)
      begin
         @(posedge clock);
         trig_in[l] <= 1'b1;
         tick(4);
         trig_in[l] <= 1'b0;
         tick(4);
      end
   endtask
   initial
   begin
      tick(10);
      sys_rst <= 1'b0;
      rd("mask", cft_pkg::ADDR_MASK, 32'h0FFFFFFF);
      rd("comp", cft_pkg::ADDR_COMP, 32'h0);
      rd("unmapped", 4'hF, 32'h0);
      rd("status", cft_pkg::ADDR_STATUS, 32'h1);
      foreach (rows[i])
      begin
         wr(cft_pkg::ADDR_MASK, {4'h0, rows[i].m});
         wr(cft_pkg::ADDR_COMP, {4'h0, rows[i].c});
         ev(0, rows[i].id, rows[i].r, rows[i].d);
         check("accept", rxq_push, rows[i].ok);
      end
      wr(cft_pkg::ADDR_MASK, 32'h0FFFFFFF);
      ev(1, 11'h123, 0, 0);
      check("warn push", rxq_push, 0);
      rd("warn flag", cft_pkg::ADDR_STATUS, 32'h3);
      rd("warn id", cft_pkg::ADDR_WARN, 32'h123);
      wr(cft_pkg::ADDR_CTRL, 32'h5);
      ev(1, 11'h124, 0, 0);
      check("warn push", rxq_push, 1);
      rd("no flag", cft_pkg::ADDR_STATUS, 32'h1);
      wr(cft_pkg::ADDR_CTRL, 32'h1);
      wr(cft_pkg::ADDR_TRIG, 32'h0601);
      // Enables follow the register written at this very edge
      #1 check("line oe", trig_oe, 7'h40);
      wr(cft_pkg::ADDR_CMD, 32'h2);
      tick(5);
      check("cmd out", outs, 1);
      check("pulse", minhi >= 2, 1);
      wr(cft_pkg::ADDR_TRIG, 32'h0602);
      ev(0, 11'h010, 0, 0);
      tick(5);
      check("rx out", outs, 2);
      wr(cft_pkg::ADDR_TRIG, 32'h0603);
      // Failing far side keeps the queue from draining while it fills
      fail_all <= 1'b1;
      delay <= 4'h6;
      s = s_now;
      for (int i = 0; i < 12; i++)
         wr(cft_pkg::ADDR_TXDATA, 32'h100 + i);
      check("retries", s_now - s > 2, 1);
      rd("full", cft_pkg::ADDR_STATUS, 32'hD1);
      fail_all <= 1'b0;
      tick(250);
      check("tx out", outs, 12);
      check("last", last_frame, 32'h109);
      wr(cft_pkg::ADDR_TRIG, 32'h0611);
      for (int i = 0; i < 2; i++)
      begin
         wr(cft_pkg::ADDR_CMD, 32'h2);
         tick(3);
         check("toggle", trig_out, i ? 7'h00 : 7'h40);
      end
      wr(cft_pkg::ADDR_CTRL, 32'h3);
      fail_all <= 1'b1;
      delay <= 4'h0;
      s = s_now;
      wr(cft_pkg::ADDR_TXDATA, 32'hBEEF);
      tick(20);
      check("one shot", s_now - s, 1);
      fail_all <= 1'b0;
      wr(cft_pkg::ADDR_TRIG, 32'h0610);
      #1 check("off oe", trig_oe, 0);
      edge_in(6, 1);
      check("off stamp", stamps, 0);
      wr(cft_pkg::ADDR_TRIG, 32'h00020314);
      #1 check("in oe", trig_oe, 0);
      edge_in(2, 1);
      edge_in(3, 6);
      check("stamps", stamps, 2);
      check("stamp line", stamp_len, 32'h3);
      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      wr(cft_pkg::ADDR_TRIG, 32'h5);
      s = s_now;
      edge_in(0, 1);
      wr(cft_pkg::ADDR_TXDATA, 32'hC1);
      wr(cft_pkg::ADDR_TXDATA, 32'hC2);
      tick(5);
      check("no edge", s_now - s, 0);
      for (int i = 0; i < 3; i++)
      begin
         edge_in(0, 1);
         check("sent", last_frame, i ? 32'hC2 : 32'hC1);
      end
      check("resend", s_now - s, 3);
      stop_test();
   end
endmodule
`default_nettype wire
